// *** src/mode_decoder.sv ***
// Decode of operating mode and bit rate codes into supported flags
`default_nettype none
module mode_decoder (
    // Configuration in
    input wire logic targetRole,
    input wire logic [3:0] operatingCode,
    input wire logic [1:0] transmitBitrate,
    input wire logic [1:0] receiveBitrate,
    // Decode out
    output logic modeSupported,
    output logic bitRateDetect,
    output logic rateSupported
);
    always_comb begin
        bitRateDetect = targetRole && operatingCode[op_mode_pkg::OMT_BRD];
        if (!targetRole) begin
            case (operatingCode)
                op_mode_pkg::OM_ACTIVE, op_mode_pkg::OM_TYPEA, op_mode_pkg::OM_TYPEB,
                op_mode_pkg::OM_TYPEF, op_mode_pkg::OM_T1T, op_mode_pkg::OM_SUBC,
                op_mode_pkg::OM_BPSK: modeSupported = 1'b1;
                default: modeSupported = 1'b0;
            endcase
        end else if (bitRateDetect) begin
            modeSupported = 1'b1;
        end else begin
            case (operatingCode)
                op_mode_pkg::OMT_TYPEA, op_mode_pkg::OMT_TYPEF,
                op_mode_pkg::OMT_ACTIVE: modeSupported = 1'b1;
                default: modeSupported = 1'b0;
            endcase
        end
        // All two-bit codes are defined rates
        rateSupported = (transmitBitrate <= 2'h3) && (receiveBitrate <= 2'h3);
    end
endmodule // mode_decoder
`default_nettype wire

// *** src/nfc_operation_mode_config.sv ***
// Operation control, mode and bit rate registers on an APB slave
`default_nettype none
module nfc_operation_mode_config (
    // Clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic powerOnRst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device events
    input wire logic crystalStable,
    input wire logic fieldOnCommand,
    input wire logic activeTransmitDone,
    input wire logic receptionDone,
    input wire logic peerFieldOff,
    input wire logic peerDetectPhase,
    // Front end controls
    output logic readyState,
    output logic receiveEnable,
    output logic transmitEnable,
    output logic amChannelOn,
    output logic pmChannelOn,
    output logic autoChannelSelect,
    output logic wakeupModeEnable,
    output logic fieldDetectorOn,
    output logic fieldDetectorPeerThreshold,
    output logic lowPowerNfcMode,
    output logic targetRole,
    output logic [3:0] operatingCode,
    output logic modulationKindSelect,
    output logic bitRateDetect,
    output logic autoFieldOn,
    output logic [1:0] transmitBitrate,
    output logic [1:0] receiveBitrate
);
    // Control register lives in its own power-on domain
    logic [7:0] operationControl;
    logic [7:0] next_operationControl;

    typedef struct packed {
        logic [7:0] modeDefinition;
        logic [7:0] bitRateDefinition;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic xtalMeta;
        logic xtalSync;
        logic rxDoneMeta;
        logic rxDoneSync;
        logic peerOffMeta;
        logic peerOffSync;
        logic phaseMeta;
        logic phaseSync;
        logic modeWriteRefused;
        logic readyState;
        logic receiveEnable;
        logic transmitEnable;
        logic amChannelOn;
        logic pmChannelOn;
        logic autoChannelSelect;
        logic wakeupModeEnable;
        logic fieldDetectorOn;
        logic fieldDetectorPeerThreshold;
        logic lowPowerNfcMode;
        logic bitRateDetect;
        logic autoFieldOn;
    } state_type;

    state_type state;
    state_type next_state;
    logic modeSupported;
    logic decBrd;
    logic rateSupported;
    logic writeAccess;
    logic [1:0] fdCode;
    logic [1:0] arCode;

    mode_decoder decoder (
        .targetRole(next_state.modeDefinition[op_mode_pkg::MD_TARG]),
        .operatingCode(next_state.modeDefinition[op_mode_pkg::MD_OMH:op_mode_pkg::MD_OML]),
        .transmitBitrate(next_state.bitRateDefinition[op_mode_pkg::RT_TXH:op_mode_pkg::RT_TXL]),
        .receiveBitrate(next_state.bitRateDefinition[op_mode_pkg::RT_RXH:op_mode_pkg::RT_RXL]),
        .modeSupported(modeSupported),
        .bitRateDetect(decBrd),
        .rateSupported(rateSupported)
    );

    assign writeAccess = psel && penable && pwrite;

    // Control register: software write, hardware set/clear of transmit bit
    always_comb begin
        next_operationControl = operationControl;
        if (writeAccess && paddr == op_mode_pkg::OPCTRL_ADDR) begin
            next_operationControl = pwdata[7:0];
        end
        if (activeTransmitDone) begin
            next_operationControl[op_mode_pkg::OC_TX] = 1'b0;
        end
        if (fieldOnCommand) begin
            next_operationControl[op_mode_pkg::OC_TX] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge powerOnRst) begin
        if (powerOnRst) begin
            operationControl <= op_mode_pkg::OPCTRL_RESET;
        end else begin
            operationControl <= next_operationControl;
        end
    end

    always_comb begin
        next_state = state;
        next_state.xtalMeta = crystalStable;
        next_state.xtalSync = state.xtalMeta;
        next_state.rxDoneMeta = receptionDone;
        next_state.rxDoneSync = state.rxDoneMeta;
        next_state.peerOffMeta = peerFieldOff;
        next_state.peerOffSync = state.peerOffMeta;
        next_state.phaseMeta = peerDetectPhase;
        next_state.phaseSync = state.phaseMeta;
        next_state.pready = psel && !penable;
        next_state.pslverr = 1'b0;
        // Register writes
        if (writeAccess) begin
            if (paddr == op_mode_pkg::MODE_ADDR) begin
                if (state.xtalSync) begin
                    next_state.modeDefinition = pwdata[7:0];
                end else begin
                    next_state.modeWriteRefused = 1'b1;
                end
            end
            if (paddr == op_mode_pkg::RATE_ADDR) begin
                next_state.bitRateDefinition = pwdata[7:0] & op_mode_pkg::RATE_MASK;
            end
            if (paddr == op_mode_pkg::EVENT_ADDR && pwdata[0]) begin
                next_state.modeWriteRefused = 1'b0;
            end
        end
        // Read data one cycle after setup
        next_state.prdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                op_mode_pkg::OPCTRL_ADDR: next_state.prdata = {24'h0, operationControl};
                op_mode_pkg::MODE_ADDR: next_state.prdata = {24'h0, state.modeDefinition};
                op_mode_pkg::RATE_ADDR: next_state.prdata = {24'h0, state.bitRateDefinition};
                op_mode_pkg::STATUS_ADDR: next_state.prdata = {29'h0, state.lowPowerNfcMode,
                    rateSupported && modeSupported, state.xtalSync};
                op_mode_pkg::EVENT_ADDR: next_state.prdata = {31'h0, state.modeWriteRefused};
                default: next_state.prdata = 32'h0;
            endcase
        end
        if (psel && !penable) begin
            case (paddr)
                op_mode_pkg::OPCTRL_ADDR, op_mode_pkg::MODE_ADDR, op_mode_pkg::RATE_ADDR,
                op_mode_pkg::STATUS_ADDR, op_mode_pkg::EVENT_ADDR: next_state.pslverr = 1'b0;
                default: next_state.pslverr = 1'b1;
            endcase
        end
        // Front end controls from the registers
        fdCode = next_operationControl[op_mode_pkg::OC_FDH:op_mode_pkg::OC_FDL];
        arCode = next_state.modeDefinition[op_mode_pkg::MD_ARH:op_mode_pkg::MD_ARL];
        next_state.readyState = next_operationControl[op_mode_pkg::OC_EN];
        next_state.receiveEnable = next_operationControl[op_mode_pkg::OC_RX]
            && modeSupported && rateSupported;
        next_state.transmitEnable = next_operationControl[op_mode_pkg::OC_TX]
            && modeSupported && rateSupported;
        // Channels: AM stays on, PM off only in single channel mode; auto pick unless single or manual; final pick lives elsewhere
        next_state.amChannelOn = 1'b1;
        next_state.pmChannelOn = !next_operationControl[op_mode_pkg::OC_CHN];
        next_state.autoChannelSelect = !next_operationControl[op_mode_pkg::OC_CHN]
            && !next_operationControl[op_mode_pkg::OC_MAN];
        next_state.wakeupModeEnable = next_operationControl[op_mode_pkg::OC_WU];
        case (fdCode)
            op_mode_pkg::FD_OFF: begin
                next_state.fieldDetectorOn = 1'b0;
                next_state.fieldDetectorPeerThreshold = 1'b0;
            end
            op_mode_pkg::FD_CA: begin
                next_state.fieldDetectorOn = 1'b1;
                next_state.fieldDetectorPeerThreshold = 1'b0;
            end
            op_mode_pkg::FD_PD: begin
                next_state.fieldDetectorOn = 1'b1;
                next_state.fieldDetectorPeerThreshold = 1'b1;
            end
            op_mode_pkg::FD_AUTO: begin
                next_state.fieldDetectorOn = 1'b1;
                next_state.fieldDetectorPeerThreshold = state.phaseSync;
            end
            default: begin
                next_state.fieldDetectorOn = 1'b0;
                next_state.fieldDetectorPeerThreshold = 1'b0;
            end
        endcase
        next_state.lowPowerNfcMode = (fdCode != op_mode_pkg::FD_OFF)
            && (next_operationControl[op_mode_pkg::OC_EN:op_mode_pkg::OC_WU] == 6'h00);
        next_state.bitRateDetect = decBrd;
        case (arCode)
            op_mode_pkg::AR_RECEIVE: next_state.autoFieldOn = state.rxDoneSync;
            op_mode_pkg::AR_PEEROFF: next_state.autoFieldOn = state.peerOffSync;
            default: next_state.autoFieldOn = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= '0;
            state.modeDefinition <= op_mode_pkg::MODE_RESET;
            state.bitRateDefinition <= op_mode_pkg::RATE_RESET;
            state.amChannelOn <= 1'b1;
            state.pmChannelOn <= 1'b1;
            state.autoChannelSelect <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // Register map outputs
    always_comb begin
        prdata = state.prdata;
        pready = state.pready;
        pslverr = state.pslverr;
        readyState = state.readyState;
        receiveEnable = state.receiveEnable;
        transmitEnable = state.transmitEnable;
        amChannelOn = state.amChannelOn;
        pmChannelOn = state.pmChannelOn;
        autoChannelSelect = state.autoChannelSelect;
        wakeupModeEnable = state.wakeupModeEnable;
        fieldDetectorOn = state.fieldDetectorOn;
        fieldDetectorPeerThreshold = state.fieldDetectorPeerThreshold;
        lowPowerNfcMode = state.lowPowerNfcMode;
        targetRole = state.modeDefinition[op_mode_pkg::MD_TARG];
        operatingCode = state.modeDefinition[op_mode_pkg::MD_OMH:op_mode_pkg::MD_OML];
        modulationKindSelect = state.modeDefinition[op_mode_pkg::MD_AM];
        bitRateDetect = state.bitRateDetect;
        autoFieldOn = state.autoFieldOn;
        transmitBitrate = state.bitRateDefinition[op_mode_pkg::RT_TXH:op_mode_pkg::RT_TXL];
        receiveBitrate = state.bitRateDefinition[op_mode_pkg::RT_RXH:op_mode_pkg::RT_RXL];
    end
endmodule // nfc_operation_mode_config
`default_nettype wire

// *** src/op_mode_pkg.sv ***
// Register map, field positions, reset values and mode codes
`default_nettype none
package op_mode_pkg;
    localparam logic [11:0] OPCTRL_ADDR = 12'h008;
    localparam logic [11:0] MODE_ADDR = 12'h00c;
    localparam logic [11:0] RATE_ADDR = 12'h010;
    localparam logic [11:0] STATUS_ADDR = 12'h014;
    localparam logic [11:0] EVENT_ADDR = 12'h018;
    localparam logic [7:0] OPCTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h08;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [7:0] RATE_MASK = 8'h33;
    localparam int OC_EN = 7;
    localparam int OC_RX = 6;
    localparam int OC_CHN = 5;
    localparam int OC_MAN = 4;
    localparam int OC_TX = 3;
    localparam int OC_WU = 2;
    localparam int OC_FDH = 1;
    localparam int OC_FDL = 0;
    localparam int MD_TARG = 7;
    localparam int MD_OMH = 6;
    localparam int MD_OML = 3;
    localparam int MD_AM = 2;
    localparam int MD_ARH = 1;
    localparam int MD_ARL = 0;
    localparam int RT_TXH = 5;
    localparam int RT_TXL = 4;
    localparam int RT_RXH = 1;
    localparam int RT_RXL = 0;
    localparam logic [3:0] OM_ACTIVE = 4'h0;
    localparam logic [3:0] OM_TYPEA = 4'h1;
    localparam logic [3:0] OM_TYPEB = 4'h2;
    localparam logic [3:0] OM_TYPEF = 4'h3;
    localparam logic [3:0] OM_T1T = 4'h4;
    localparam logic [3:0] OM_SUBC = 4'he;
    localparam logic [3:0] OM_BPSK = 4'hf;
    localparam logic [3:0] OMT_TYPEA = 4'h1;
    localparam logic [3:0] OMT_TYPEF = 4'h4;
    localparam logic [3:0] OMT_ACTIVE = 4'h7;
    localparam int OMT_BRD = 3;
    localparam int OMT_BRD_F = 2;
    localparam int OMT_BRD_A = 0;
    localparam logic [1:0] FD_OFF = 2'h0;
    localparam logic [1:0] FD_CA = 2'h1;
    localparam logic [1:0] FD_PD = 2'h2;
    localparam logic [1:0] FD_AUTO = 2'h3;
    localparam logic [1:0] AR_RECEIVE = 2'h1;
    localparam logic [1:0] AR_PEEROFF = 2'h2;
endpackage : op_mode_pkg
`default_nettype wire

// *** test/nfc_operation_mode_config_sva.sv ***
// Concurrent checks on the operation mode register block ports
`default_nettype none
module nfc_operation_mode_config_sva (
    // Clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic powerOnRst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Controls
    input wire logic crystalStable,
    input wire logic readyState,
    input wire logic receiveEnable,
    input wire logic transmitEnable,
    input wire logic amChannelOn,
    input wire logic pmChannelOn,
    input wire logic lowPowerNfcMode,
    input wire logic targetRole,
    input wire logic [3:0] operatingCode,
    input wire logic modulationKindSelect,
    input wire logic [1:0] transmitBitrate,
    input wire logic [1:0] receiveBitrate
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic wrAcc = psel && penable && pready && pwrite;
    wire logic wrCtrl = wrAcc && paddr == op_mode_pkg::OPCTRL_ADDR;
    wire logic wrMode = wrAcc && paddr == op_mode_pkg::MODE_ADDR;
    wire logic wrRate = wrAcc && paddr == op_mode_pkg::RATE_ADDR;
    wire logic topBit = pwdata[7];
    wire logic amBit = pwdata[2];
    wire logic [1:0] txField = pwdata[5:4];
    wire logic [1:0] rxField = pwdata[1:0];
    wire logic badMode = targetRole ? (!operatingCode[3] && !(operatingCode inside {4'h1, 4'h4,
        4'h7})) : (operatingCode inside {[4'h5:4'hd]});
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst || powerOnRst);
    tx_rate_load_a: assert property (wrRate |=> transmitBitrate == $past(txField))
        else $error("transmit rate not loaded");
    rx_rate_load_a: assert property (wrRate |=> receiveBitrate == $past(rxField))
        else $error("receive rate not loaded");
    ready_follow_a: assert property (wrCtrl |-> ##2 readyState == $past(topBit, 2))
        else $error("ready state does not follow control bit");
    one_channel_a: assert property (amChannelOn || pmChannelOn)
        else $error("no receive channel active");
    low_power_a: assert property (lowPowerNfcMode |-> !readyState && !receiveEnable
        && amChannelOn && pmChannelOn) else $error("low power mode with other bits set");
    mode_accept_a: assert property (crystalStable [*4] ##0 wrMode |-> ##2
        targetRole == $past(topBit, 2) && modulationKindSelect == $past(amBit, 2))
        else $error("mode write not applied");
    mode_refuse_a: assert property (!crystalStable [*4] ##0 wrMode |=>
        $stable(targetRole) [*2]) else $error("mode write taken without crystal");
    bad_mode_off_a: assert property (badMode |-> !transmitEnable && !receiveEnable)
        else $error("unsupported mode leaves transfer enabled");
    rate_rsv_zero_a: assert property (psel && pready && !pwrite
        && paddr == op_mode_pkg::RATE_ADDR |-> (prdata & 32'hffffffcc) == 32'h0)
        else $error("reserved rate bits read nonzero");
endmodule // nfc_operation_mode_config_sva
`default_nettype wire

// *** test/nfc_operation_mode_config_tb.sv ***
// Self-checking bench for the operation mode register block
`default_nettype none
module nfc_operation_mode_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, sys_rst = 1'h1, powerOnRst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, crystalStable = 1'h1, fieldOnCommand = 1'h0, activeTransmitDone = 1'h0;
    logic receptionDone = 1'h0, peerFieldOff = 1'h0, peerDetectPhase = 1'h0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, readyState, receiveEnable, transmitEnable, amChannelOn, pmChannelOn;
    logic autoChannelSelect, wakeupModeEnable, fieldDetectorOn, fieldDetectorPeerThreshold;
    logic lowPowerNfcMode, targetRole, modulationKindSelect, bitRateDetect, autoFieldOn;
    logic [3:0] operatingCode;
    logic [1:0] transmitBitrate, receiveBitrate;
    int errors = 0, checked = 0;
    localparam logic [7:0] CW [8] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01, 8'h02, 8'h81, 8'h00};
    localparam logic [6:0] CE [8] = '{7'h50, 7'h30, 7'h00, 7'h18, 7'h15, 7'h17, 7'h54, 7'h10};
    always #50 clk = ~clk;
    nfc_operation_mode_config i_nfc_operation_mode_config (
        .clk(clk), .sys_rst(sys_rst), .powerOnRst(powerOnRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystalStable(crystalStable), .fieldOnCommand(fieldOnCommand),
        .activeTransmitDone(activeTransmitDone), .receptionDone(receptionDone),
        .peerFieldOff(peerFieldOff), .peerDetectPhase(peerDetectPhase), .readyState(readyState),
        .receiveEnable(receiveEnable), .transmitEnable(transmitEnable),
        .amChannelOn(amChannelOn), .pmChannelOn(pmChannelOn),
        .autoChannelSelect(autoChannelSelect), .wakeupModeEnable(wakeupModeEnable),
        .fieldDetectorOn(fieldDetectorOn), .fieldDetectorPeerThreshold(fieldDetectorPeerThreshold),
        .lowPowerNfcMode(lowPowerNfcMode), .targetRole(targetRole), .operatingCode(operatingCode),
        .modulationKindSelect(modulationKindSelect), .bitRateDetect(bitRateDetect),
        .autoFieldOn(autoFieldOn), .transmitBitrate(transmitBitrate),
        .receiveBitrate(receiveBitrate));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("Counts: %0d errors in %0d checks", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 16)
            errors++;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(rd, e);
    endtask
    // Sample outputs once the edge's updates have landed
    task automatic wt(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        rdchk(op_mode_pkg::OPCTRL_ADDR, 32'h0);
        rdchk(op_mode_pkg::MODE_ADDR, 32'h8);
        rdchk(op_mode_pkg::RATE_ADDR, 32'h0);
        apb(1'h0, 12'h040, 32'h0);
        check({31'h0, err}, 32'h1);
    endtask
    task automatic t_ctrl;
        for (int i = 0; i < 8; i++) begin
            wr(op_mode_pkg::OPCTRL_ADDR, {24'h0, CW[i]});
            wt(2);
            check({25'h0, readyState, receiveEnable, autoChannelSelect, wakeupModeEnable,
                fieldDetectorOn, fieldDetectorPeerThreshold, lowPowerNfcMode}, {25'h0, CE[i]});
        end
        wr(op_mode_pkg::OPCTRL_ADDR, 32'h20);
        wt(2);
        check({30'h0, amChannelOn & pmChannelOn, amChannelOn | pmChannelOn}, 32'h1);
        @(posedge clk) peerDetectPhase <= 1'h1;
        wr(op_mode_pkg::OPCTRL_ADDR, 32'h03);
        wt(6);
        check({31'h0, fieldDetectorPeerThreshold}, 32'h1);
        @(posedge clk) peerDetectPhase <= 1'h0;
        wt(6);
        check({31'h0, fieldDetectorPeerThreshold}, 32'h0);
    endtask
    task automatic t_power;
        wr(op_mode_pkg::OPCTRL_ADDR, 32'h80);
        @(posedge clk) sys_rst <= 1'h1;
        @(posedge clk) sys_rst <= 1'h0;
        rdchk(op_mode_pkg::OPCTRL_ADDR, 32'h80);
        wt(2);
        check({31'h0, readyState}, 32'h1);
        @(posedge clk) powerOnRst <= 1'h1;
        @(posedge clk) powerOnRst <= 1'h0;
        rdchk(op_mode_pkg::OPCTRL_ADDR, 32'h0);
    endtask
    task automatic t_tx;
        wr(op_mode_pkg::OPCTRL_ADDR, 32'h80);
        @(posedge clk) fieldOnCommand <= 1'h1;
        @(posedge clk) fieldOnCommand <= 1'h0;
        wt(2);
        check({31'h0, transmitEnable}, 32'h1);
        rdchk(op_mode_pkg::OPCTRL_ADDR, 32'h88);
        @(posedge clk) activeTransmitDone <= 1'h1;
        @(posedge clk) activeTransmitDone <= 1'h0;
        wt(2);
        check({31'h0, transmitEnable}, 32'h0);
    endtask
    task automatic t_mode;
        logic [4:0] m;
        logic ok;
        wr(op_mode_pkg::OPCTRL_ADDR, 32'hc8);
        for (int i = 0; i < 32; i++) begin
            m = 5'(i);
            ok = m[4] ? (m[3] || m[3:0] inside {4'h1, 4'h4, 4'h7}) : !(m[3:0] inside {[4'h5:4'hd]});
            wr(op_mode_pkg::MODE_ADDR, {24'h0, m, 3'h4});
            wt(2);
            check({23'h0, transmitEnable, receiveEnable, bitRateDetect, modulationKindSelect,
                targetRole, operatingCode}, {23'h0, ok, ok, m[4] & m[3], 1'h1, m});
        end
        wr(op_mode_pkg::MODE_ADDR, 32'h08);
        wt(2);
        check({31'h0, modulationKindSelect}, 32'h0);
    endtask
    task automatic t_refuse;
        @(posedge clk) crystalStable <= 1'h0;
        wt(4);
        wr(op_mode_pkg::MODE_ADDR, 32'h88);
        rdchk(op_mode_pkg::MODE_ADDR, 32'h08);
        rdchk(op_mode_pkg::EVENT_ADDR, 32'h1);
        wr(op_mode_pkg::EVENT_ADDR, 32'h1);
        rdchk(op_mode_pkg::EVENT_ADDR, 32'h0);
        @(posedge clk) crystalStable <= 1'h1;
        wt(4);
        wr(op_mode_pkg::MODE_ADDR, 32'h88);
        rdchk(op_mode_pkg::MODE_ADDR, 32'h88);
    endtask
    task automatic t_rate;
        for (int i = 0; i < 16; i++) begin
            wr(op_mode_pkg::RATE_ADDR, {24'h0, 2'h3, i[3:2], 2'h3, i[1:0]});
            wt(2);
            check({27'h0, transmitEnable, transmitBitrate, receiveBitrate}, {27'h0, 1'h1, i[3:0]});
            rdchk(op_mode_pkg::RATE_ADDR, {26'h0, i[3:2], 2'h0, i[1:0]});
        end
    endtask
    task automatic t_auto;
        for (int i = 0; i < 8; i++) begin
            wr(op_mode_pkg::MODE_ADDR, {24'h0, 6'h02, i[2:1]});
            @(posedge clk) begin
                receptionDone <= !i[0];
                peerFieldOff <= i[0];
            end
            wt(6);
            check({31'h0, autoFieldOn}, {31'h0, i[2:1] == {i[0], !i[0]}});
            @(posedge clk) begin
                receptionDone <= 1'h0;
                peerFieldOff <= 1'h0;
            end
            wt(6);
        end
    endtask
    initial begin
        #2000000;
        errors++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        powerOnRst <= 1'h0;
        t_reset();
        t_ctrl();
        t_power();
        t_tx();
        t_mode();
        t_refuse();
        t_rate();
        t_auto();
        finish_test();
    end
endmodule // nfc_operation_mode_config_tb
bind nfc_operation_mode_config nfc_operation_mode_config_sva i_nfc_operation_mode_config_sva (
    .clk(clk), .sys_rst(sys_rst), .powerOnRst(powerOnRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .crystalStable(crystalStable), .readyState(readyState), .receiveEnable(receiveEnable),
    .transmitEnable(transmitEnable), .amChannelOn(amChannelOn), .pmChannelOn(pmChannelOn),
    .lowPowerNfcMode(lowPowerNfcMode), .targetRole(targetRole), .operatingCode(operatingCode),
    .modulationKindSelect(modulationKindSelect), .transmitBitrate(transmitBitrate),
    .receiveBitrate(receiveBitrate));
`default_nettype wire
